//--- logic/t16b_core.sv
// 16-bit timer counter core with byte-wide access via a shared holding byte
`timescale 1ns/100ps
`default_nettype none

module t16b_core
    import t16b_pkg::*;
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    // register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata,
    // external clock pin
    input  wire logic              ext_clk_pin,
    // status
    output logic                   overflow_flag,
    output logic                   at_top,
    output logic                   at_bottom,
    output logic      [CNT_W-1:0]  count_value
);

    logic [DATA_W-1:0] timer_ctrl_a;
    logic [DATA_W-1:0] timer_ctrl_b;
    logic [DATA_W-1:0] hold_byte;
    logic [CNT_W-1:0]  compare_value_a;
    logic [CNT_W-1:0]  compare_value_b;
    logic [CNT_W-1:0]  capture_value;
    logic              count_down;

    logic [DATA_W-1:0] next_ctrl_a;
    logic [DATA_W-1:0] next_ctrl_b;
    logic [DATA_W-1:0] next_hold;
    logic [CNT_W-1:0]  next_cmp_a;
    logic [CNT_W-1:0]  next_cmp_b;
    logic [CNT_W-1:0]  next_capt;
    logic [CNT_W-1:0]  next_count;
    logic              next_down;
    logic              next_ovf;
    logic [DATA_W-1:0] next_rdata;

    logic [3:0]        wave_mode_field;
    logic [2:0]        clock_select_field;
    logic [CNT_W-1:0]  top_value;
    logic              dual;
    logic              timer_tick;
    logic              cnt_wr;
    logic              ovf_set;

    ////////////////////////////////////////////////////////////////////////
    // control fields
    assign wave_mode_field    = {timer_ctrl_b[CTRL_B_WM_LSB +: 2],
                                 timer_ctrl_a[CTRL_A_WM_LSB +: 2]};
    assign clock_select_field = timer_ctrl_b[CTRL_B_CS_LSB +: 3];
    assign top_value          = t16b_top(wave_mode_field, compare_value_a,
                                         capture_value);
    assign dual               = t16b_dual(wave_mode_field);
    assign cnt_wr             = wr && (addr == OFS_COUNT_LO);
    assign at_top             = (count_value == top_value);
    assign at_bottom          = (count_value == CNT_BOTTOM);

    t16b_tick_gen u_tick (
        .mclk               (mclk),
        .sys_rst            (sys_rst),
        .clock_select_field (clock_select_field),
        .ext_clk_pin        (ext_clk_pin),
        .timer_tick         (timer_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // register writes and holding byte
    always_comb
    begin
        next_ctrl_a = timer_ctrl_a;
        next_ctrl_b = timer_ctrl_b;
        next_hold   = hold_byte;
        next_cmp_a  = compare_value_a;
        next_cmp_b  = compare_value_b;
        next_capt   = capture_value;
        if (wr)
        begin
            if (addr == OFS_CTRL_A)
            begin
                next_ctrl_a = wdata;
            end
            else if (addr == OFS_CTRL_B)
            begin
                next_ctrl_b = wdata;
            end
            else if (addr == OFS_COUNT_HI || addr == OFS_CMP_A_HI ||
                     addr == OFS_CMP_B_HI || addr == OFS_CAPT_HI)
            begin
                next_hold = wdata;
            end
            else if (addr == OFS_CMP_A_LO)
            begin
                next_cmp_a = {hold_byte, wdata};
            end
            else if (addr == OFS_CMP_B_LO)
            begin
                next_cmp_b = {hold_byte, wdata};
            end
            else if (addr == OFS_CAPT_LO)
            begin
                next_capt = {hold_byte, wdata};
            end
        end
        else if (rd)
        begin
            if (addr == OFS_COUNT_LO)
            begin
                next_hold = count_value[CNT_W-1:DATA_W];
            end
            else if (addr == OFS_CAPT_LO)
            begin
                next_hold = capture_value[CNT_W-1:DATA_W];
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            timer_ctrl_a    <= RST_BYTE;
            timer_ctrl_b    <= RST_BYTE;
            hold_byte       <= RST_BYTE;
            compare_value_a <= RST_WORD;
            compare_value_b <= RST_WORD;
            capture_value   <= RST_WORD;
        end
        else
        begin
            timer_ctrl_a    <= next_ctrl_a;
            timer_ctrl_b    <= next_ctrl_b;
            hold_byte       <= next_hold;
            compare_value_a <= next_cmp_a;
            compare_value_b <= next_cmp_b;
            capture_value   <= next_capt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counter unit
    always_comb
    begin
        next_count = count_value;
        next_down  = count_down;
        ovf_set    = 1'b0;
        if (cnt_wr)
        begin
            next_count = {hold_byte, wdata};
        end
        else if (timer_tick)
        begin
            if (dual)
            begin
                if (!count_down && count_value == top_value)
                begin
                    next_down  = 1'b1;
                    next_count = count_value - CNT_STEP;
                end
                else if (count_down && count_value == CNT_BOTTOM)
                begin
                    next_down  = 1'b0;
                    next_count = count_value + CNT_STEP;
                    ovf_set    = 1'b1;
                end
                else if (count_down)
                begin
                    next_count = count_value - CNT_STEP;
                end
                else
                begin
                    next_count = count_value + CNT_STEP;
                end
            end
            else
            begin
                next_down = 1'b0;
                if (count_value == top_value)
                begin
                    next_count = CNT_BOTTOM;
                end
                else
                begin
                    next_count = count_value + CNT_STEP;
                end
                if (wave_mode_field == WM_CTC_A || wave_mode_field == WM_CTC_C)
                begin
                    ovf_set = (count_value == CNT_MAX);
                end
                else
                begin
                    ovf_set = (count_value == top_value);
                end
            end
        end
        // set wins over a write-one clear
        next_ovf = overflow_flag;
        if (wr && addr == OFS_FLAGS && wdata[FLAG_OVF_BIT])
        begin
            next_ovf = 1'b0;
        end
        if (ovf_set)
        begin
            next_ovf = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            count_value   <= RST_WORD;
            count_down    <= 1'b0;
            overflow_flag <= 1'b0;
        end
        else
        begin
            count_value   <= next_count;
            count_down    <= next_down;
            overflow_flag <= next_ovf;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, valid the cycle after the strobe
    always_comb
    begin
        next_rdata = RST_BYTE;
        if (rd)
        begin
            if (addr == OFS_CTRL_A)
            begin
                next_rdata = timer_ctrl_a;
            end
            else if (addr == OFS_CTRL_B)
            begin
                next_rdata = timer_ctrl_b;
            end
            else if (addr == OFS_COUNT_LO)
            begin
                next_rdata = count_value[DATA_W-1:0];
            end
            else if (addr == OFS_COUNT_HI || addr == OFS_CAPT_HI)
            begin
                next_rdata = hold_byte;
            end
            else if (addr == OFS_CMP_A_LO)
            begin
                next_rdata = compare_value_a[DATA_W-1:0];
            end
            else if (addr == OFS_CMP_A_HI)
            begin
                next_rdata = compare_value_a[CNT_W-1:DATA_W];
            end
            else if (addr == OFS_CMP_B_LO)
            begin
                next_rdata = compare_value_b[DATA_W-1:0];
            end
            else if (addr == OFS_CMP_B_HI)
            begin
                next_rdata = compare_value_b[CNT_W-1:DATA_W];
            end
            else if (addr == OFS_CAPT_LO)
            begin
                next_rdata = capture_value[DATA_W-1:0];
            end
            else if (addr == OFS_FLAGS)
            begin
                next_rdata[FLAG_OVF_BIT] = overflow_flag;
                next_rdata[FLAG_DIR_BIT] = count_down;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            rdata <= RST_BYTE;
        end
        else
        begin
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_lo_write;
        (wr && addr == OFS_COUNT_LO) |=> count_value == {$past(hold_byte), $past(wdata)};
    endproperty
    a_lo_write: assert property (p_lo_write)
        else $error("low write did not load full count");

    property p_lo_read;
        (rd && addr == OFS_COUNT_LO) |=> hold_byte == $past(count_value[15:8])
            && rdata == $past(count_value[7:0]);
    endproperty
    a_lo_read: assert property (p_lo_read)
        else $error("low read did not latch high byte");

    property p_hi_read;
        (rd && addr == OFS_COUNT_HI) |=> rdata == $past(hold_byte);
    endproperty
    a_hi_read: assert property (p_hi_read)
        else $error("high read did not return holding byte");

    property p_cmp_read;
        (rd && (addr == OFS_CMP_A_LO || addr == OFS_CMP_B_HI)) |=> $stable(hold_byte);
    endproperty
    a_cmp_read: assert property (p_cmp_read)
        else $error("compare read touched holding byte");

    property p_hold_keep;
        (wr && addr == OFS_CMP_A_LO) ##1 (!wr && !rd) ##1 (wr && addr == OFS_CMP_B_LO)
            |=> compare_value_b[15:8] == compare_value_a[15:8];
    endproperty
    a_hold_keep: assert property (p_hold_keep)
        else $error("holding byte not reused");

    property p_stopped;
        (clock_select_field == CS_STOP && !cnt_wr) ##1 !cnt_wr
            |=> $stable(count_value);
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("counter moved while stopped");

    property p_no_tick;
        (!timer_tick && !cnt_wr) |=> $stable(count_value);
    endproperty
    a_no_tick: assert property (p_no_tick)
        else $error("counter moved without tick");

    property p_step;
        (timer_tick && !cnt_wr && wave_mode_field == WM_NORMAL)
            |=> count_value == $past(count_value) + CNT_STEP;
    endproperty
    a_step: assert property (p_step)
        else $error("normal mode step not one");

    property p_ovf;
        (timer_tick && !cnt_wr && wave_mode_field == WM_NORMAL && count_value == CNT_MAX)
            |=> overflow_flag && count_value == CNT_BOTTOM;
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow flag not set at max");

    property p_wr_wins;
        (cnt_wr && timer_tick) |=> count_value == {$past(hold_byte), $past(wdata)};
    endproperty
    a_wr_wins: assert property (p_wr_wins)
        else $error("count beat a cpu write");

    property p_reset;
        disable iff (1'b0) sys_rst |=> count_value == CNT_BOTTOM && hold_byte == RST_BYTE
            && clock_select_field == CS_STOP;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset state not zero");

    c_wrap: cover property (timer_tick && count_value == top_value);
    c_turn: cover property (timer_tick && dual && count_down && at_bottom);
    c_pair: cover property ((wr && addr == OFS_COUNT_HI) ##2 (wr && addr == OFS_COUNT_LO));
    c_read: cover property ((rd && addr == OFS_COUNT_LO) ##2 (rd && addr == OFS_COUNT_HI));

endmodule

`default_nettype wire

//--- logic/t16b_pkg.sv
// shared constants and helpers for the 16-bit timer counter core
package t16b_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 16;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL_A    = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CTRL_B    = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_COUNT_LO  = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_COUNT_HI  = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_CMP_A_LO  = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CMP_A_HI  = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_CMP_B_LO  = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_CMP_B_HI  = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_CAPT_LO   = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_CAPT_HI   = 4'h9;
    localparam logic [ADDR_W-1:0] OFS_FLAGS     = 4'ha;

    // field positions
    localparam int CTRL_A_WM_LSB = 0;  // wave mode bits 1:0
    localparam int CTRL_B_WM_LSB = 3;  // wave mode bits 3:2
    localparam int CTRL_B_CS_LSB = 0;  // clock select bits 2:0
    localparam int FLAG_OVF_BIT  = 0;
    localparam int FLAG_DIR_BIT  = 1;

    // reset values
    localparam logic [DATA_W-1:0] RST_BYTE  = 8'h00;
    localparam logic [CNT_W-1:0]  RST_WORD  = 16'h0000;

    // counter landmarks
    localparam logic [CNT_W-1:0] CNT_BOTTOM = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX    = 16'hffff;
    localparam logic [CNT_W-1:0] TOP_8BIT   = 16'h00ff;
    localparam logic [CNT_W-1:0] TOP_9BIT   = 16'h01ff;
    localparam logic [CNT_W-1:0] TOP_10BIT  = 16'h03ff;
    localparam logic [CNT_W-1:0] CNT_STEP   = 16'h0001;

    // clock select codes
    localparam logic [2:0] CS_STOP     = 3'h0;
    localparam logic [2:0] CS_DIV1     = 3'h1;
    localparam logic [2:0] CS_DIV8     = 3'h2;
    localparam logic [2:0] CS_DIV64    = 3'h3;
    localparam logic [2:0] CS_DIV256   = 3'h4;
    localparam logic [2:0] CS_DIV1024  = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;

    // prescaler tap masks
    localparam int PRE_W = 10;
    localparam logic [PRE_W-1:0] PRE_MASK_8    = 10'h007;
    localparam logic [PRE_W-1:0] PRE_MASK_64   = 10'h03f;
    localparam logic [PRE_W-1:0] PRE_MASK_256  = 10'h0ff;
    localparam logic [PRE_W-1:0] PRE_MASK_1024 = 10'h3ff;
    localparam logic [PRE_W-1:0] PRE_ONE       = 10'h001;

    // wave mode codes
    localparam logic [3:0] WM_NORMAL = 4'h0;
    localparam logic [3:0] WM_CTC_A  = 4'h4;
    localparam logic [3:0] WM_CTC_C  = 4'hc;

    // top value of the counting sequence for a wave mode
    function automatic logic [CNT_W-1:0] t16b_top(input logic [3:0] wm,
                                                   input logic [CNT_W-1:0] cmp_a,
                                                   input logic [CNT_W-1:0] capt);
        logic [CNT_W-1:0] t;
        t = CNT_MAX;
        case (wm)
            4'h1, 4'h5:                t = TOP_8BIT;
            4'h2, 4'h6:                t = TOP_9BIT;
            4'h3, 4'h7:                t = TOP_10BIT;
            4'h4, 4'h9, 4'hb, 4'hf:    t = cmp_a;
            4'h8, 4'ha, 4'hc, 4'he:    t = capt;
            default:                   t = CNT_MAX;
        endcase
        return t;
    endfunction

    // dual-slope (up then down) modes
    function automatic logic t16b_dual(input logic [3:0] wm);
        return (wm inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
    endfunction

endpackage

//--- logic/t16b_tick_gen.sv
// clock select: prescaled internal tick or synchronised external edge
`timescale 1ns/100ps
`default_nettype none

module t16b_tick_gen
    import t16b_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // selection and source
    input  wire logic [2:0] clock_select_field,
    input  wire logic       ext_clk_pin,
    // tick out
    output logic            timer_tick
);

    logic [PRE_W-1:0] pre;
    logic [PRE_W-1:0] next_pre;
    logic             sync1;
    logic             sync2;
    logic             sync3;
    logic             next_tick;
    logic [PRE_W-1:0] mask;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_pre  = pre + PRE_ONE;
        mask      = PRE_MASK_1024;
        next_tick = 1'b0;
        case (clock_select_field)
            CS_STOP:     next_tick = 1'b0;
            CS_DIV1:     next_tick = 1'b1;
            CS_DIV8:     mask      = PRE_MASK_8;
            CS_DIV64:    mask      = PRE_MASK_64;
            CS_DIV256:   mask      = PRE_MASK_256;
            CS_DIV1024:  mask      = PRE_MASK_1024;
            CS_EXT_FALL: next_tick = sync3 & ~sync2;
            default:     next_tick = sync2 & ~sync3;
        endcase
        if (clock_select_field inside {CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024})
        begin
            next_tick = ((pre & mask) == mask);
        end
    end

    // single-cycle enable in the mclk domain
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            pre        <= '0;
            sync1      <= 1'b0;
            sync2      <= 1'b0;
            sync3      <= 1'b0;
            timer_tick <= 1'b0;
        end
        else
        begin
            pre        <= next_pre;
            sync1      <= ext_clk_pin;
            sync2      <= sync1;
            sync3      <= sync2;
            timer_tick <= next_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_stop_no_tick;
        @(posedge mclk) disable iff (sys_rst)
        (clock_select_field == CS_STOP) |=> !timer_tick;
    endproperty
    a_stop_no_tick: assert property (p_stop_no_tick)
        else $error("tick while clock select is zero");

endmodule

`default_nettype wire

//--- sim/t16b_cpu_model.sv
// cpu side model: byte-wide master of the register port
`timescale 1ns/100ps
`default_nettype none

module t16b_cpu_model
    import t16b_pkg::*;
(
    // clock
    input  wire logic              mclk,
    // register port
    output logic      [ADDR_W-1:0] addr,
    output logic      [DATA_W-1:0] wdata,
    output logic                   wr,
    output logic                   rd,
    input  wire logic [DATA_W-1:0] rdata
);
    initial
    begin
        addr  = 4'h0;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // one byte per access
    task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
        wdata <= ~d;
    endtask

    task automatic get(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    // high byte first, one idle cycle between the two writes
    task automatic put16(input logic [ADDR_W-1:0] lo, input logic [CNT_W-1:0] v);
        put(lo + 4'h1, v[15:8]);
        put(lo, v[7:0]);
    endtask
endmodule

`default_nettype wire

//--- sim/timer16_byte_access_counter_test.sv
// self-checking bench for the timer counter core
`timescale 1ns/100ps
`default_nettype none

module timer16_byte_access_counter_test;
    import t16b_pkg::*;

    logic              mclk;
    logic              sys_rst;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] rdata;
    logic              overflow_flag;
    logic              at_top;
    logic              at_bottom;
    logic [CNT_W-1:0]  count_value;
    logic [DATA_W-1:0] d;
    logic              ext_pin;
    int                num_errors;
    int                n_compared;
    int                cycles;

    t16b_core dut (.mclk(mclk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .ext_clk_pin(ext_pin), .overflow_flag(overflow_flag),
        .at_top(at_top), .at_bottom(at_bottom), .count_value(count_value));
    t16b_cpu_model cpu (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));

    task automatic check(input logic [CNT_W-1:0] seen, input logic [CNT_W-1:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("errors %0d compares %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic wait_top();
        for (int i = 0; i < 20 && at_top !== 1'b1; i++)
            @(posedge mclk) #1;
    endtask

    task automatic t_reset();
        check(count_value, RST_WORD);
        check({15'h0, at_bottom}, 16'h0001);
        check({15'h0, overflow_flag}, 16'h0000);
        cpu.get(OFS_CTRL_B, d);
        check({8'h0, d}, 16'h0000);
        cpu.get(OFS_COUNT_HI, d);
        check({8'h0, d}, 16'h0000);
        cpu.get(4'hb, d);
        check({8'h0, d}, 16'h0000);
    endtask

    task automatic t_bytes();
        cpu.put16(OFS_COUNT_LO, 16'h1234);
        #1 check(count_value, 16'h1234);
        cpu.put(OFS_COUNT_HI, 8'h77);
        #1 check(count_value, 16'h1234);
        cpu.get(OFS_COUNT_LO, d);
        check({8'h0, d}, 16'h0034);
        cpu.get(OFS_COUNT_HI, d);
        check({8'h0, d}, 16'h0012);
        cpu.put(OFS_CMP_A_HI, 8'hab);
        cpu.put(OFS_CMP_A_LO, 8'h01);
        cpu.put(OFS_CMP_B_LO, 8'h02);
        cpu.put(OFS_CAPT_LO, 8'h03);
        cpu.get(OFS_CMP_B_HI, d);
        check({8'h0, d}, 16'h00ab);
        cpu.get(OFS_COUNT_LO, d);
        cpu.get(OFS_CAPT_LO, d);
        cpu.get(OFS_CAPT_HI, d);
        check({8'h0, d}, 16'h00ab);
        cpu.get(OFS_COUNT_LO, d);
        cpu.get(OFS_CMP_A_LO, d);
        check({8'h0, d}, 16'h0001);
        cpu.get(OFS_COUNT_HI, d);
        check({8'h0, d}, 16'h0012);
    endtask

    task automatic t_count();
        logic [CNT_W-1:0] v;
        cpu.put16(OFS_COUNT_LO, 16'hfffd);
        cpu.put(OFS_CTRL_B, {5'h0, CS_DIV1});
        wait_top();
        check(count_value, CNT_MAX);
        check({15'h0, at_top}, 16'h0001);
        @(posedge mclk) #1;
        check(count_value, CNT_BOTTOM);
        check({14'h0, at_bottom, overflow_flag}, 16'h0003);
        cpu.put16(OFS_COUNT_LO, 16'h0500);
        #1 check(count_value, 16'h0500);
        cpu.put(OFS_CTRL_B, {5'h0, CS_STOP});
        repeat (3) @(posedge mclk);
        v = count_value;
        repeat (10) @(posedge mclk);
        check(count_value, v);
        cpu.put(OFS_FLAGS, 8'h01);
        cpu.get(OFS_FLAGS, d);
        check({8'h0, d}, 16'h0000);
    endtask

    task automatic t_down();
        cpu.put16(OFS_COUNT_LO, 16'h00fd);
        cpu.put(OFS_CTRL_A, 8'h01);
        cpu.put(OFS_CTRL_B, {5'h0, CS_DIV1});
        wait_top();
        check(count_value, TOP_8BIT);
        @(posedge mclk) #1;
        check(count_value, 16'h00fe);
        cpu.put(OFS_CTRL_B, {5'h0, CS_STOP});
        cpu.get(OFS_FLAGS, d);
        check({15'h0, d[FLAG_DIR_BIT]}, 16'h0001);
    endtask

    // 64 cycles of divide-by-8, then three falling pin edges
    task automatic t_clk();
        cpu.put(OFS_CTRL_A, 8'h00);
        cpu.put16(OFS_COUNT_LO, RST_WORD);
        cpu.put(OFS_CTRL_B, {5'h0, CS_DIV8});
        repeat (62) @(posedge mclk);
        cpu.put(OFS_CTRL_B, {5'h0, CS_STOP});
        @(posedge mclk) #1;
        check(count_value, 16'h0008);
        cpu.put16(OFS_COUNT_LO, RST_WORD);
        cpu.put(OFS_CTRL_B, {5'h0, CS_EXT_FALL});
        repeat (3)
        begin
            @(posedge mclk) ext_pin <= 1'b1;
            repeat (2) @(posedge mclk);
            ext_pin <= 1'b0;
            repeat (2) @(posedge mclk);
        end
        ext_pin <= 1'b1;
        repeat (8) @(posedge mclk) #1;
        check(count_value, 16'h0003);
        cpu.put(OFS_CTRL_B, {5'h0, CS_STOP});
    endtask

    // compare A as top, overflow only at max
    task automatic t_ctc();
        cpu.put16(OFS_CMP_A_LO, 16'h0005);
        cpu.put16(OFS_COUNT_LO, RST_WORD);
        cpu.put(OFS_CTRL_B, {3'h0, WM_CTC_A[3:2], CS_DIV1});
        wait_top();
        check(count_value, 16'h0005);
        @(posedge mclk) #1;
        check({14'h0, at_bottom, overflow_flag}, 16'h0002);
        cpu.put(OFS_CTRL_B, {5'h0, CS_STOP});
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            report_and_stop();
        end
    end

    initial
    begin
        sys_rst = 1'b1;
        ext_pin = 1'b0;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk) #1;
        t_reset();
        t_bytes();
        t_count();
        t_down();
        t_clk();
        t_ctc();
        report_and_stop();
    end
endmodule

`default_nettype wire
